// ==== irq_enable_params.svh ====
// Notes on behaviour
// - Register at 0x71B: bits 7..4 logic cells 4..1, bits 2..0 timer gates 5,3,1.
// - Register at 0x71C: bits 4..0 capture/compare units 5..1, rest read zero.
// - Register at 0x71D: bit5 memory ctrl, bit4 osc generator, bits 2..0 waveform gens.
// - Register at 0x71E: measurement timers 2 and 1 pulse, period, overflow enables.
// - An enable bit of one enables its source, zero disables it.
// - No peripheral interrupt takes effect unless the shared peripheral gate is set.
`ifndef IRQ_ENABLE_PARAMS_SVH
`define IRQ_ENABLE_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define LOGIC_TIMER_EN_OFFSET 12'h71b
`define CAPCOMP_EN_OFFSET     12'h71c
`define MEM_OSC_WAVE_EN_OFFSET 12'h71d
`define MEAS_TIMER_EN_OFFSET  12'h71e
`define CORE_IRQ_CTRL_OFFSET  12'h71f

// ****************************************************************
// Implemented bit masks and reset values
// ****************************************************************
`define LOGIC_TIMER_EN_MASK   8'hf7
`define CAPCOMP_EN_MASK       8'h1f
`define MEM_OSC_WAVE_EN_MASK  8'h37
`define MEAS_TIMER_EN_MASK    8'h3f
`define CORE_IRQ_CTRL_MASK    8'h40
`define PERIPH_GATE_BIT       6
`define ENABLE_RESET          8'h00

`endif

// ==== irq_enable_pkg.sv ====
`default_nettype none
package irq_enable_pkg;
  // Register selected by a bus address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_LOGIC_TIMER,
    SEL_CAPCOMP,
    SEL_MEM_OSC_WAVE,
    SEL_MEAS_TIMER,
    SEL_CORE_CTRL
  } reg_sel_t;
endpackage
`default_nettype wire

// ==== irq_gate_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Enables, pending flags and gate travelling to the request combiner
interface irq_gate_if;
  logic [31:0] enables;
  logic [31:0] pending;
  logic        gate;
  logic        request;
  modport bank (output enables, output pending, output gate, input request);
  modport comb (input enables, input pending, input gate, output request);
endinterface
`default_nettype wire

// ==== irq_request_comb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "irq_enable_params.svh"
module irq_request_comb (
  input  wire logic  sys_clk,
  input  wire logic  rst_n,
  irq_gate_if.comb   gif
);
  // ****************************************************************
  // Gated request
  // ****************************************************************
  // Registered so the core sees a clean level
  logic request_reg;
  logic request_next;
  wire  any_enabled = |(gif.enables & gif.pending);
  assign request_next = gif.gate & any_enabled;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) request_reg <= 1'b0;
    else request_reg <= request_next;
  end
  assign gif.request = request_reg;

  AST_GATE_BLOCKS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !gif.gate |=> !request_reg) else $error("Request with gate clear");
  AST_REQ_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    request_reg |-> $past(gif.gate) && ($past(gif.enables & gif.pending) != 32'h0))
    else $error("Request without cause");
  AST_REQ_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    gif.gate && any_enabled |=> request_reg) else $error("Enabled pending source not requested");
  COV_REQ: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(request_reg));
endmodule
`default_nettype wire

// ==== peripheral_irq_enable_bank.sv ====
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "irq_enable_params.svh"
module peripheral_irq_enable_bank (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [7:0]  logic_timer_pending,
  input  wire logic [7:0]  capcomp_pending,
  input  wire logic [7:0]  mem_osc_wave_pending,
  input  wire logic [7:0]  meas_timer_pending,
  output logic             periph_irq_req
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  // Enable banks, one byte each; only implemented bits are ever stored
  logic [7:0]               logic_timer_reg;
  logic [7:0]               capcomp_reg;
  logic [7:0]               mem_osc_wave_reg;
  logic [7:0]               meas_timer_reg;
  logic [7:0]               core_ctrl_reg;
  logic [7:0]               logic_timer_next;
  logic [7:0]               capcomp_next;
  logic [7:0]               mem_osc_wave_next;
  logic [7:0]               meas_timer_next;
  logic [7:0]               core_ctrl_next;
  logic [7:0]               rdata_reg;
  logic [7:0]               rdata_next;
  irq_enable_pkg::reg_sel_t sel;

  // Address decode
  function automatic irq_enable_pkg::reg_sel_t decode(input logic [11:0] a);
    unique case (a)
      `LOGIC_TIMER_EN_OFFSET:  decode = irq_enable_pkg::SEL_LOGIC_TIMER;
      `CAPCOMP_EN_OFFSET:      decode = irq_enable_pkg::SEL_CAPCOMP;
      `MEM_OSC_WAVE_EN_OFFSET: decode = irq_enable_pkg::SEL_MEM_OSC_WAVE;
      `MEAS_TIMER_EN_OFFSET:   decode = irq_enable_pkg::SEL_MEAS_TIMER;
      `CORE_IRQ_CTRL_OFFSET:   decode = irq_enable_pkg::SEL_CORE_CTRL;
      default:                 decode = irq_enable_pkg::SEL_NONE;
    endcase
  endfunction
  assign sel = decode(reg_addr);

  // ****************************************************************
  // Write and read decode
  // ****************************************************************
  // One strobe per register; an unmapped address raises none of them
  wire wr_lt = reg_wr && sel == irq_enable_pkg::SEL_LOGIC_TIMER;
  wire wr_cc = reg_wr && sel == irq_enable_pkg::SEL_CAPCOMP;
  wire wr_mw = reg_wr && sel == irq_enable_pkg::SEL_MEM_OSC_WAVE;
  wire wr_mt = reg_wr && sel == irq_enable_pkg::SEL_MEAS_TIMER;
  wire wr_cr = reg_wr && sel == irq_enable_pkg::SEL_CORE_CTRL;

  // Read strobes per register, watched by the read checks below
  wire rd_lt   = reg_rd && sel == irq_enable_pkg::SEL_LOGIC_TIMER;
  wire rd_cc   = reg_rd && sel == irq_enable_pkg::SEL_CAPCOMP;
  wire rd_mw   = reg_rd && sel == irq_enable_pkg::SEL_MEM_OSC_WAVE;
  wire rd_mt   = reg_rd && sel == irq_enable_pkg::SEL_MEAS_TIMER;
  wire rd_cr   = reg_rd && sel == irq_enable_pkg::SEL_CORE_CTRL;
  wire rd_none = reg_rd && sel == irq_enable_pkg::SEL_NONE;

  // ****************************************************************
  // Register update
  // ****************************************************************
  // Masking at write time keeps unimplemented bits zero without read muxing
  assign logic_timer_next  = wr_lt ? (reg_wdata & `LOGIC_TIMER_EN_MASK) : logic_timer_reg;
  assign capcomp_next      = wr_cc ? (reg_wdata & `CAPCOMP_EN_MASK) : capcomp_reg;
  assign mem_osc_wave_next = wr_mw ? (reg_wdata & `MEM_OSC_WAVE_EN_MASK) : mem_osc_wave_reg;
  assign meas_timer_next   = wr_mt ? (reg_wdata & `MEAS_TIMER_EN_MASK) : meas_timer_reg;
  assign core_ctrl_next    = wr_cr ? (reg_wdata & `CORE_IRQ_CTRL_MASK) : core_ctrl_reg;

  // Unimplemented bits are never stored, so they always read zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      logic_timer_reg  <= `ENABLE_RESET;
      capcomp_reg      <= `ENABLE_RESET;
      mem_osc_wave_reg <= `ENABLE_RESET;
      meas_timer_reg   <= `ENABLE_RESET;
      core_ctrl_reg    <= `ENABLE_RESET;
    end else begin
      logic_timer_reg  <= logic_timer_next;
      capcomp_reg      <= capcomp_next;
      mem_osc_wave_reg <= mem_osc_wave_next;
      meas_timer_reg   <= meas_timer_next;
      core_ctrl_reg    <= core_ctrl_next;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Unmapped addresses read zero; data valid only the cycle after strobe
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      unique case (sel)
        irq_enable_pkg::SEL_LOGIC_TIMER:  rdata_next = logic_timer_reg;
        irq_enable_pkg::SEL_CAPCOMP:      rdata_next = capcomp_reg;
        irq_enable_pkg::SEL_MEM_OSC_WAVE: rdata_next = mem_osc_wave_reg;
        irq_enable_pkg::SEL_MEAS_TIMER:   rdata_next = meas_timer_reg;
        irq_enable_pkg::SEL_CORE_CTRL:    rdata_next = core_ctrl_reg;
        irq_enable_pkg::SEL_NONE:         rdata_next = 8'h00;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) rdata_reg <= 8'h00;
    else rdata_reg <= rdata_next;
  end
  assign reg_rdata = rdata_reg;

  // ****************************************************************
  // Request combining
  // ****************************************************************
  irq_gate_if gif ();
  assign gif.enables = {meas_timer_reg, mem_osc_wave_reg, capcomp_reg, logic_timer_reg};
  assign gif.pending = {meas_timer_pending, mem_osc_wave_pending,
                        capcomp_pending, logic_timer_pending};
  assign gif.gate    = core_ctrl_reg[`PERIPH_GATE_BIT];
  irq_request_comb u_comb (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .gif     (gif.comb)
  );
  assign periph_irq_req = gif.request;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_LT_MASK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_lt |=> logic_timer_reg == $past(reg_wdata & `LOGIC_TIMER_EN_MASK))
    else $error("Logic/timer enable write wrong");
  // Capture/compare write keeps only the five unit enables
  AST_CC_MASK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_cc |=> capcomp_reg == $past(reg_wdata & `CAPCOMP_EN_MASK))
    else $error("Capture enable write wrong");
  AST_MW_MASK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_mw |=> mem_osc_wave_reg == $past(reg_wdata & `MEM_OSC_WAVE_EN_MASK))
    else $error("Memory/osc/wave enable write wrong");
  AST_MT_MASK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_mt |=> meas_timer_reg == $past(reg_wdata & `MEAS_TIMER_EN_MASK))
    else $error("Measurement enable write wrong");
  AST_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && sel == irq_enable_pkg::SEL_LOGIC_TIMER && !reg_wr |=> reg_rdata == $past(logic_timer_reg))
    else $error("Read data mismatch");
  AST_NO_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00) else $error("Read data without strobe");

  // ****************************************************************
  // Further register checks
  // ****************************************************************
  // Gate control write keeps only the gate bit
  AST_CORE_MASK: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_cr |=> core_ctrl_reg == $past(reg_wdata & `CORE_IRQ_CTRL_MASK))
    else $error("Gate control write wrong");

  // A register holds its value when its own strobe is low
  AST_LT_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr_lt |=> $stable(logic_timer_reg))
    else $error("Logic/timer enables changed without write");
  AST_CC_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr_cc |=> $stable(capcomp_reg))
    else $error("Capture enables changed without write");
  AST_MW_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr_mw |=> $stable(mem_osc_wave_reg))
    else $error("Memory/osc/wave enables changed without write");
  AST_MT_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr_mt |=> $stable(meas_timer_reg))
    else $error("Measurement enables changed without write");

  // Each register reads back in the cycle after its strobe
  AST_READ_CC: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_cc |=> reg_rdata == $past(capcomp_reg))
    else $error("Capture enable read mismatch");
  AST_READ_MW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_mw |=> reg_rdata == $past(mem_osc_wave_reg))
    else $error("Memory/osc/wave enable read mismatch");
  AST_READ_MT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_mt |=> reg_rdata == $past(meas_timer_reg))
    else $error("Measurement enable read mismatch");
  AST_READ_CORE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_cr |=> reg_rdata == $past(core_ctrl_reg))
    else $error("Gate control read mismatch");

  // Unmapped addresses read zero, so software sees no phantom bank
  AST_READ_NONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_none |=> reg_rdata == 8'h00)
    else $error("Unmapped address read nonzero");

  // The read strobe for the first bank is decoded as intended
  AST_READ_LT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_lt |=> reg_rdata == $past(logic_timer_reg))
    else $error("Logic/timer enable read mismatch");

  // ****************************************************************
  // Request checks at the top output
  // ****************************************************************
  // A live enabled source behind an open gate raises the request
  AST_REQ_LT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    gif.gate && (logic_timer_reg & logic_timer_pending) != 8'h00 |=> periph_irq_req)
    else $error("Enabled logic/timer source not requested");

  // Without gate or without an enabled pending source the line stays low
  AST_REQ_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !gif.gate || (gif.enables & gif.pending) == 32'h0 |=> !periph_irq_req)
    else $error("Request raised without cause");

  // ****************************************************************
  // Coverage of the main scenarios
  // ****************************************************************
  COV_WRITE_CC: cover property (@(posedge sys_clk) disable iff (!rst_n) wr_cc);
  COV_GATE_ON: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(gif.gate));
  COV_READ_MT: cover property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && sel == irq_enable_pkg::SEL_MEAS_TIMER);
  // Gate open with an enabled capture/compare source pending
  COV_REQ_CC: cover property (@(posedge sys_clk) disable iff (!rst_n)
    gif.gate && (capcomp_reg & capcomp_pending) != 8'h00);
endmodule
`default_nettype wire

// ==== peripheral_irq_enable_bank_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_enable_bank_tb;
  // ****************************************************************
  // Stimulus and observation signals
  // ****************************************************************
  logic        sys_clk, rst_n, reg_wr, reg_rd;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [7:0]  pend [4];
  logic        periph_irq_req;
  logic [7:0]  mask [4] = '{8'hf7, 8'h1f, 8'h37, 8'h3f};
  int          mismatches, n_compared;

  peripheral_irq_enable_bank u_peripheral_irq_enable_bank (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .logic_timer_pending(pend[0]), .capcomp_pending(pend[1]),
    .mem_osc_wave_pending(pend[2]), .meas_timer_pending(pend[3]),
    .periph_irq_req(periph_irq_req));

  // ****************************************************************
  // Bus and check tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
    @(posedge sys_clk) reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge sys_clk) begin reg_addr <= a; reg_rd <= 1'b1; end
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask
  // Two edges cover the one-cycle request latency with margin
  task automatic req_chk(input int i, input logic [7:0] p, input logic e);
    @(posedge sys_clk) pend[i] <= p;
    repeat (2) @(posedge sys_clk);
    #1 chk("periph_irq_req", {7'h00, e}, {7'h00, periph_irq_req});
  endtask
  task automatic final_report();
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and test sequence
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Tests need under 500 cycles; this limit only catches a hang
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 12'h000; reg_wdata = 8'h00;
    for (int i = 0; i < 4; i++) pend[i] = 8'h00;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset values, implemented bits and clearing of every enable register
    for (int i = 0; i < 4; i++) begin
      rd(12'h71b + 12'(i), 8'h00);
      wr(12'h71b + 12'(i), 8'hff);
      rd(12'h71b + 12'(i), mask[i]);
      wr(12'h71b + 12'(i), 8'h00);
      rd(12'h71b + 12'(i), 8'h00);
    end
    // Neighbouring unmapped addresses keep nothing; gate control at 0x71F keeps only bit 6
    wr(12'h71a, 8'hff);
    rd(12'h71a, 8'h00);
    wr(12'h720, 8'hff);
    rd(12'h720, 8'h00);
    wr(12'h71f, 8'hff);
    rd(12'h71f, 8'h40);
    // Each bit alone: other pendings must not fire it, its own must if the bit is implemented
    for (int i = 0; i < 4; i++) begin
      for (int b = 0; b < 8; b++) begin
        wr(12'h71b + 12'(i), 8'h01 << b);
        req_chk(i, ~(8'h01 << b), 1'b0);
        req_chk(i, 8'h01 << b, mask[i][b]);
        req_chk(i, 8'h00, 1'b0);
      end
      wr(12'h71b + 12'(i), 8'h00);
    end
    // Gate off blocks a live source, gate on lets it through again
    wr(12'h71e, 8'h20);
    req_chk(3, 8'h20, 1'b1);
    wr(12'h71f, 8'h00);
    req_chk(3, 8'h20, 1'b0);
    wr(12'h71f, 8'h40);
    req_chk(3, 8'h20, 1'b1);
    wr(12'h71e, 8'h00);
    req_chk(3, 8'h20, 1'b0);
    // A second reset in mid-run clears the enables and the gate again
    wr(12'h71b, 8'hff);
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(12'h71b, 8'h00);
    rd(12'h71f, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
